// ==== logic/rx_cond_consts.svh ====
`ifndef RX_COND_CONSTS_SVH
`define RX_COND_CONSTS_SVH

// control bus map
`define CBUS_ADDR_W 5
`define ADDR_RX_COND_A 5'h09
`define ADDR_RX_COND_B 5'h0A

// reset values: both limit flags come up set
`define RX_COND_A_RESET 8'h20
`define RX_COND_B_RESET 8'h02

// group a bit positions
`define BIT_NO_CARRIER 0
`define BIT_QUIET_LINE 1
`define BIT_HALT_LINE 2
`define BIT_MASTER_LINE 3
`define BIT_NOISE_LINE 4
`define BIT_NOISE_LIMIT 5
`define BIT_LINE_CHANGE 6
`define BIT_UNKNOWN_INV 7

// group b bit positions
`define BIT_IDLE_LINE 0
`define BIT_COUNT_LIMIT 1
`define BIT_ACTIVE_LINE 2
`define BIT_UNKNOWN_VAL 3
`define BIT_CONN_SYNC_ERR 4
`define BIT_ELASTIC_FAULT 5
`define BIT_LONG_IDLE 6
`define BIT_RESERVED_B 7

// symbol pair codes, first symbol in the upper five bits
`define SYM_QUIET_PAIR 10'h000
`define SYM_HALT_PAIR 10'h084
`define SYM_MASTER_PAIR 10'h080
`define SYM_IDLE_PAIR 10'h3FF
`define SYM_JK_PAIR 10'h311

// run lengths and event counts
`define RUN_W 4
`define RUN_MAX 4'hF
`define RUN_QUIET_MIN 4'h8
`define RUN_HALT_MIN 4'h8
`define RUN_MASTER_MIN 4'h8
`define RUN_IDLE_MIN 4'h2
`define RUN_LONG_IDLE 4'h8
`define NOISE_W 5
`define NOISE_EVENTS_MIN 5'h10

// cascade start window, longest time so rounded down
`define CLK_PERIOD_NS 20
`define CASCADE_GO_NS 80
`define CASCADE_WIN_CYCLES (`CASCADE_GO_NS / `CLK_PERIOD_NS)
`define CASCADE_CNT_W 3

`endif

// ==== logic/rx_cond_pkg.sv ====
package rx_cond_pkg;

    // receiver line states
    typedef enum logic [2:0] {
        LS_NO_SIGNAL = 3'b000,
        LS_QUIET = 3'b001,
        LS_HALT = 3'b010,
        LS_MASTER = 3'b011,
        LS_NOISE = 3'b100,
        LS_ACTIVE = 3'b101,
        LS_IDLE = 3'b110,
        LS_UNKNOWN = 3'b111
    } line_state_e;

    // classes of a received symbol pair
    typedef enum logic [2:0] {
        CLS_QUIET = 3'b000,
        CLS_HALT = 3'b001,
        CLS_MASTER = 3'b010,
        CLS_IDLE = 3'b011,
        CLS_JK = 3'b100,
        CLS_OTHER = 3'b101
    } pair_class_e;

endpackage : rx_cond_pkg

// ==== logic/line_state_tracker.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "rx_cond_consts.svh"

module line_state_tracker
    import rx_cond_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // receive path
    input wire logic carrier_detect_in,
    input wire logic pair_valid,
    input wire logic [9:0] pair_code,
    input wire logic code_violation,
    input wire logic noise_event,
    // line state events
    output var line_state_e line_state,
    output logic state_enter,
    output logic long_idle_seen,
    output logic unknown_inv,
    output logic unknown_val
);

    line_state_e state_reg;
    line_state_e state_next;
    line_state_e known_reg;
    pair_class_e cls_reg;
    pair_class_e pair_cls;
    logic [`RUN_W-1:0] run_reg;
    logic [`RUN_W-1:0] run_next;
    logic [`NOISE_W-1:0] noise_reg;
    logic [`NOISE_W-1:0] noise_next;
    logic same_cls;
    logic enter_now;
    logic known_entry;
    logic enter_reg;
    logic long_idle_reg;
    logic unk_inv_reg;
    logic unk_val_reg;

    // classify the pair
    assign pair_cls = (pair_code == `SYM_QUIET_PAIR) ? CLS_QUIET :
                      (pair_code == `SYM_HALT_PAIR) ? CLS_HALT :
                      (pair_code == `SYM_MASTER_PAIR) ? CLS_MASTER :
                      (pair_code == `SYM_IDLE_PAIR) ? CLS_IDLE :
                      (pair_code == `SYM_JK_PAIR) ? CLS_JK : CLS_OTHER;
    assign same_cls = (pair_cls == cls_reg);
    assign run_next = !same_cls ? `RUN_W'(1) :
                      (run_reg == `RUN_MAX) ? run_reg : run_reg + `RUN_W'(1);

    // noise events accumulate until a known state other than noise is entered
    assign known_entry = enter_reg && (state_reg != LS_NOISE) && (state_reg != LS_UNKNOWN);
    assign noise_next = known_entry ? `NOISE_W'(0) :
                        (noise_event && noise_reg < `NOISE_EVENTS_MIN) ? noise_reg + `NOISE_W'(1) : noise_reg;

    // pair runs win over noise so a clean line always leaves the noise state
    assign state_next = !carrier_detect_in ? LS_NO_SIGNAL :
        (pair_valid && pair_cls == CLS_JK) ? LS_ACTIVE :
        (pair_valid && pair_cls == CLS_QUIET && run_next >= `RUN_QUIET_MIN) ? LS_QUIET :
        (pair_valid && pair_cls == CLS_HALT && run_next >= `RUN_HALT_MIN) ? LS_HALT :
        (pair_valid && pair_cls == CLS_MASTER && run_next >= `RUN_MASTER_MIN) ? LS_MASTER :
        (pair_valid && pair_cls == CLS_IDLE && run_next >= `RUN_IDLE_MIN) ? LS_IDLE :
        (noise_reg >= `NOISE_EVENTS_MIN) ? LS_NOISE :
        code_violation ? LS_UNKNOWN :
        !pair_valid ? state_reg :
        (state_reg == LS_ACTIVE) ? LS_ACTIVE :
        same_cls ? state_reg : LS_UNKNOWN;
    assign enter_now = (state_next != state_reg);

    // state and run counters
    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= LS_UNKNOWN;
            known_reg <= LS_NO_SIGNAL;
            cls_reg <= CLS_OTHER;
            run_reg <= `RUN_W'(0);
            noise_reg <= `NOISE_W'(0);
        end else begin
            state_reg <= state_next;
            noise_reg <= noise_next;
            if (pair_valid) begin
                cls_reg <= pair_cls;
                run_reg <= run_next;
            end
            if (enter_now && state_next != LS_UNKNOWN) begin
                known_reg <= state_next;
            end
        end
    end

    // event pulses, one cycle each
    always_ff @(posedge clk) begin
        if (reset) begin
            enter_reg <= 1'b0;
            long_idle_reg <= 1'b0;
            unk_inv_reg <= 1'b0;
            unk_val_reg <= 1'b0;
        end else begin
            enter_reg <= enter_now;
            long_idle_reg <= pair_valid && pair_cls == CLS_IDLE && run_next == `RUN_LONG_IDLE;
            unk_inv_reg <= enter_now && state_next == LS_UNKNOWN &&
                           known_reg != LS_ACTIVE && known_reg != LS_IDLE;
            unk_val_reg <= enter_now && state_next == LS_UNKNOWN &&
                           (known_reg == LS_ACTIVE || known_reg == LS_IDLE);
        end
    end

    assign line_state = state_reg;
    assign state_enter = enter_reg;
    assign long_idle_seen = long_idle_reg;
    assign unknown_inv = unk_inv_reg;
    assign unknown_val = unk_val_reg;

endmodule : line_state_tracker

`default_nettype wire

// ==== logic/rx_line_state_event_regs.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "rx_cond_consts.svh"

module rx_line_state_event_regs
    import rx_cond_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // receive path from the line state detector
    input wire logic carrier_detect_in,
    input wire logic pair_valid,
    input wire logic [9:0] pair_code,
    input wire logic code_violation,
    input wire logic noise_event,
    // noise and state counters
    input wire logic noise_count_zero,
    input wire logic noise_threshold_load,
    input wire logic state_count_zero,
    input wire logic state_threshold_load,
    // connection management and elastic buffer
    input wire logic [7:0] connection_event_reg,
    input wire logic [7:0] connection_event_mask,
    input wire logic elastic_overflow,
    input wire logic elastic_underflow,
    // cascade handshake
    input wire logic cascade_enable,
    input wire logic cascade_ready,
    input wire logic cascade_go,
    // mask registers held elsewhere
    input wire logic [7:0] rx_enable_mask_a,
    input wire logic [7:0] rx_enable_mask_b,
    // control bus
    input wire logic [`CBUS_ADDR_W-1:0] cbus_addr,
    input wire logic cbus_rd,
    input wire logic cbus_wr,
    input wire logic [7:0] cbus_wdata,
    output logic [7:0] cbus_rdata,
    // summary bits toward the interrupt summary register
    output logic group_a_summary,
    output logic group_b_summary
);

    line_state_e line_state;
    logic state_enter;
    logic long_idle_seen;
    logic unknown_inv;
    logic unknown_val;

    logic [7:0] cond_a_reg;
    logic [7:0] cond_b_reg;
    logic [7:0] cond_a_next;
    logic [7:0] cond_b_next;
    logic [7:0] seen_a_reg;
    logic [7:0] seen_b_reg;
    logic [7:0] set_a;
    logic [7:0] set_b;
    logic [7:0] clr_a;
    logic [7:0] clr_b;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic sum_a_reg;
    logic sum_b_reg;
    logic noise_hold_reg;
    logic state_hold_reg;
    logic ready_prev_reg;
    logic cas_wait_reg;
    logic [`CASCADE_CNT_W-1:0] cas_cnt_reg;
    logic cas_err_reg;
    logic cas_release;
    logic cas_expire;
    logic conn_hit;
    logic sel_a;
    logic sel_b;

    // line state recognition lives in its own module
    line_state_tracker tracker (
        .clk(clk),
        .reset(reset),
        .carrier_detect_in(carrier_detect_in),
        .pair_valid(pair_valid),
        .pair_code(pair_code),
        .code_violation(code_violation),
        .noise_event(noise_event),
        .line_state(line_state),
        .state_enter(state_enter),
        .long_idle_seen(long_idle_seen),
        .unknown_inv(unknown_inv),
        .unknown_val(unknown_val)
    );

    // address decode
    assign sel_a = (cbus_addr == `ADDR_RX_COND_A);
    assign sel_b = (cbus_addr == `ADDR_RX_COND_B);

    // limit holds: a reload releases the hold, the zero level reasserts it
    always_ff @(posedge clk) begin
        if (reset) begin
            noise_hold_reg <= 1'b1;
            state_hold_reg <= 1'b1;
        end else begin
            noise_hold_reg <= noise_count_zero || (noise_hold_reg && !noise_threshold_load);
            state_hold_reg <= state_count_zero || (state_hold_reg && !state_threshold_load);
        end
    end

    // cascade start window watch; only armed in cascade mode, since the
    // error bit is shared with connection events
    assign cas_release = cascade_enable && ready_prev_reg && !cascade_ready;
    assign cas_expire = cas_wait_reg && !cascade_go &&
                        (cas_cnt_reg == `CASCADE_CNT_W'(`CASCADE_WIN_CYCLES));

    always_ff @(posedge clk) begin
        if (reset) begin
            ready_prev_reg <= 1'b0;
            cas_wait_reg <= 1'b0;
            cas_cnt_reg <= `CASCADE_CNT_W'(0);
            cas_err_reg <= 1'b0;
        end else begin
            ready_prev_reg <= cascade_ready;
            cas_err_reg <= cas_expire;
            if (cas_release) begin
                cas_wait_reg <= !cascade_go;
                cas_cnt_reg <= `CASCADE_CNT_W'(1);
            end else if (cas_wait_reg) begin
                cas_wait_reg <= !cascade_go && !cas_expire;
                cas_cnt_reg <= cas_cnt_reg + `CASCADE_CNT_W'(1);
            end
        end
    end

    assign conn_hit = |(connection_event_reg & connection_event_mask);

    // hardware set sources, group a
    assign set_a[`BIT_NO_CARRIER] = !carrier_detect_in;
    assign set_a[`BIT_QUIET_LINE] = state_enter && line_state == LS_QUIET;
    assign set_a[`BIT_HALT_LINE] = state_enter && line_state == LS_HALT;
    assign set_a[`BIT_MASTER_LINE] = state_enter && line_state == LS_MASTER;
    assign set_a[`BIT_NOISE_LINE] = state_enter && line_state == LS_NOISE;
    assign set_a[`BIT_NOISE_LIMIT] = noise_hold_reg;
    assign set_a[`BIT_LINE_CHANGE] = state_enter;
    assign set_a[`BIT_UNKNOWN_INV] = unknown_inv;

    // hardware set sources, group b
    assign set_b[`BIT_IDLE_LINE] = state_enter && line_state == LS_IDLE;
    assign set_b[`BIT_COUNT_LIMIT] = state_hold_reg;
    assign set_b[`BIT_ACTIVE_LINE] = state_enter && line_state == LS_ACTIVE;
    assign set_b[`BIT_UNKNOWN_VAL] = unknown_val;
    assign set_b[`BIT_CONN_SYNC_ERR] = conn_hit || cas_err_reg;
    assign set_b[`BIT_ELASTIC_FAULT] = elastic_overflow || elastic_underflow;
    assign set_b[`BIT_LONG_IDLE] = long_idle_seen;
    assign set_b[`BIT_RESERVED_B] = 1'b0;

    // conditional clear: only bits that were set at the last read and are
    // written as zero, so an event recorded after the read is not thrown away
    assign clr_a = (cbus_wr && sel_a) ? (seen_a_reg & ~cbus_wdata) : 8'h00;
    assign clr_b = (cbus_wr && sel_b) ? (seen_b_reg & ~cbus_wdata) : 8'h00;

    // per-bit update, set beats clear, nothing clears but software
    generate
        for (genvar i = 0; i < 8; i++) begin : g_bits
            assign cond_a_next[i] = set_a[i] || (cond_a_reg[i] && !clr_a[i]);
            assign cond_b_next[i] = set_b[i] || (cond_b_reg[i] && !clr_b[i]);
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (reset) begin
            cond_a_reg <= `RX_COND_A_RESET;
            cond_b_reg <= `RX_COND_B_RESET;
        end else begin
            cond_a_reg <= cond_a_next;
            cond_b_reg <= cond_b_next;
        end
    end

    // read data; other addresses belong to other blocks and read zero here
    assign rdata_next = !cbus_rd ? rdata_reg :
                        sel_a ? cond_a_reg :
                        sel_b ? cond_b_reg : 8'h00;

    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_reg <= 8'h00;
            seen_a_reg <= 8'h00;
            seen_b_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
            if (cbus_rd && sel_a) begin
                seen_a_reg <= cond_a_reg;
            end
            if (cbus_rd && sel_b) begin
                seen_b_reg <= cond_b_reg;
            end
        end
    end

    // summary bits, one cycle behind the event registers
    always_ff @(posedge clk) begin
        if (reset) begin
            sum_a_reg <= 1'b0;
            sum_b_reg <= 1'b0;
        end else begin
            sum_a_reg <= |(cond_a_reg & rx_enable_mask_a);
            sum_b_reg <= |(cond_b_reg & rx_enable_mask_b);
        end
    end

    assign cbus_rdata = rdata_reg;
    assign group_a_summary = sum_a_reg;
    assign group_b_summary = sum_b_reg;

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    history_kept_a: assert property (
        !(cbus_wr && sel_a) |=> ((cond_a_reg & $past(cond_a_reg)) == $past(cond_a_reg)))
        else $error("group a event bit dropped without a clear");

    history_kept_b: assert property (
        !(cbus_wr && sel_b) |=> ((cond_b_reg & $past(cond_b_reg)) == $past(cond_b_reg)))
        else $error("group b event bit dropped without a clear");

    summary_a_a: assert property (
        (|(cond_a_reg & rx_enable_mask_a)) |=> group_a_summary)
        else $error("group a summary missed an enabled event");

    summary_b_a: assert property (
        (cond_b_reg & rx_enable_mask_b) == 8'h00 |=> !group_b_summary)
        else $error("group b summary high with no enabled event");

    no_carrier_a: assert property (
        !carrier_detect_in |=> cond_a_reg[`BIT_NO_CARRIER])
        else $error("no carrier flag not set");

    reset_limits_a: assert property (
        $fell(reset) |-> cond_a_reg[`BIT_NOISE_LIMIT] && cond_b_reg[`BIT_COUNT_LIMIT])
        else $error("limit flags clear after reset");

    noise_limit_a: assert property (
        noise_count_zero |=> ##1 cond_a_reg[`BIT_NOISE_LIMIT])
        else $error("noise limit flag not set at zero count");

    count_limit_a: assert property (
        state_count_zero ##1 !state_threshold_load |=> cond_b_reg[`BIT_COUNT_LIMIT])
        else $error("count limit flag released without reload");

    line_change_a: assert property (
        state_enter |=> cond_a_reg[`BIT_LINE_CHANGE])
        else $error("line change flag not set");

    conn_event_a: assert property (
        conn_hit |=> cond_b_reg[`BIT_CONN_SYNC_ERR])
        else $error("connection event not recorded");

    cascade_window_a: assert property (
        cas_release && !cascade_go ##1 !cascade_go [*4] |-> ##2 cond_b_reg[`BIT_CONN_SYNC_ERR])
        else $error("cascade sync error not recorded");

    elastic_fault_a: assert property (
        (elastic_overflow || elastic_underflow) |=> cond_b_reg[`BIT_ELASTIC_FAULT])
        else $error("elastic buffer fault not recorded");

    reserved_bit_a: assert property (
        !cond_b_reg[`BIT_RESERVED_B])
        else $error("reserved bit set");

    set_wins_a: assert property (
        cbus_wr && sel_a && set_a != 8'h00 |=> ((cond_a_reg & $past(set_a)) == $past(set_a)))
        else $error("clear overrode a hardware set");

    quiet_seen_a: assert property (
        state_enter && line_state == LS_QUIET |=> cond_a_reg[`BIT_QUIET_LINE])
        else $error("quiet line flag not set");

    halt_seen_a: assert property (
        state_enter && line_state == LS_HALT |=> cond_a_reg[`BIT_HALT_LINE])
        else $error("halt line flag not set");

    master_seen_a: assert property (
        state_enter && line_state == LS_MASTER |=> cond_a_reg[`BIT_MASTER_LINE])
        else $error("master line flag not set");

    noise_seen_a: assert property (
        state_enter && line_state == LS_NOISE |=> cond_a_reg[`BIT_NOISE_LINE])
        else $error("noise line flag not set");

    unknown_inv_a: assert property (
        unknown_inv |=> cond_a_reg[`BIT_UNKNOWN_INV])
        else $error("unknown after invalid not recorded");

    idle_seen_a: assert property (
        state_enter && line_state == LS_IDLE |=> cond_b_reg[`BIT_IDLE_LINE])
        else $error("idle line flag not set");

    active_seen_a: assert property (
        state_enter && line_state == LS_ACTIVE |=> cond_b_reg[`BIT_ACTIVE_LINE])
        else $error("active line flag not set");

    unknown_val_a: assert property (
        unknown_val |=> cond_b_reg[`BIT_UNKNOWN_VAL])
        else $error("unknown after valid not recorded");

    long_idle_a: assert property (
        long_idle_seen |=> cond_b_reg[`BIT_LONG_IDLE])
        else $error("long idle flag not set");

    summary_b_hi_a: assert property (
        (|(cond_b_reg & rx_enable_mask_b)) |=> group_b_summary)
        else $error("group b summary missed an enabled event");

    summary_a_lo_a: assert property (
        (cond_a_reg & rx_enable_mask_a) == 8'h00 |=> !group_a_summary)
        else $error("group a summary high with no enabled event");

endmodule : rx_line_state_event_regs

`default_nettype wire

// ==== testbench/smt_host.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "rx_cond_consts.svh"

module smt_host (
    // clock
    input wire logic clk,
    // control bus toward the device
    output logic [`CBUS_ADDR_W-1:0] cbus_addr,
    output logic cbus_rd,
    output logic cbus_wr,
    output logic [7:0] cbus_wdata,
    input wire logic [7:0] cbus_rdata
);
    // bus idle at time zero
    initial begin
        cbus_addr = '0;
        cbus_rd = 1'b0;
        cbus_wr = 1'b0;
        cbus_wdata = 8'h00;
    end

    // read: strobe taken at one edge, data settled just after it
    task automatic rd(input logic [`CBUS_ADDR_W-1:0] a, output logic [7:0] d);
        @(posedge clk);
        cbus_addr <= a;
        cbus_rd <= 1'b1;
        @(posedge clk);
        cbus_rd <= 1'b0;
        #1 d = cbus_rdata;
    endtask : rd

    // write: data flipped after release so stale values never pass
    task automatic wr(input logic [`CBUS_ADDR_W-1:0] a, input logic [7:0] v);
        @(posedge clk);
        cbus_addr <= a;
        cbus_wdata <= v;
        cbus_wr <= 1'b1;
        @(posedge clk);
        cbus_wr <= 1'b0;
        cbus_wdata <= ~v;
    endtask : wr

    // clear every bit seen set: read first, then write zeros
    task automatic clr(input logic [`CBUS_ADDR_W-1:0] a);
        logic [7:0] d;
        rd(a, d);
        wr(a, 8'h00);
    endtask : clr
endmodule : smt_host
`default_nettype wire

// ==== testbench/rx_line_state_event_regs_test.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "rx_cond_consts.svh"

module rx_line_state_event_regs_test;
    logic clk = 1'b0, reset = 1'b1, carrier_detect_in = 1'b1, pair_valid = 1'b0;
    logic cascade_enable = 1'b0, cascade_ready = 1'b0, cascade_go = 1'b0;
    // pulsed inputs share one vector, since a ref argument cannot take a nonblocking assignment
    localparam int VIOL = 0, NOISE = 1, NZERO = 2, NLOAD = 3, SZERO = 4, SLOAD = 5, OVER = 6, UNDER = 7;
    logic [7:0] strobe = 8'h00;
    wire logic code_violation = strobe[VIOL], noise_event = strobe[NOISE], noise_count_zero = strobe[NZERO];
    wire logic noise_threshold_load = strobe[NLOAD], state_count_zero = strobe[SZERO];
    wire logic state_threshold_load = strobe[SLOAD], elastic_overflow = strobe[OVER];
    wire logic elastic_underflow = strobe[UNDER];
    logic [9:0] pair_code = 10'h000;
    logic [7:0] conn_reg = 8'h00, conn_mask = 8'h00, mask_a = 8'h00, mask_b = 8'h00, cbus_rdata, cbus_wdata;
    logic [`CBUS_ADDR_W-1:0] cbus_addr;
    logic cbus_rd, cbus_wr, group_a_summary, group_b_summary;
    int mismatches = 0, total_checks = 0;
    localparam logic [4:0] RA = `ADDR_RX_COND_A, RB = `ADDR_RX_COND_B;

    // 50 MHz clock
    always #10 clk = ~clk;

    rx_line_state_event_regs DUT (.clk(clk), .reset(reset), .carrier_detect_in(carrier_detect_in),
        .pair_valid(pair_valid), .pair_code(pair_code), .code_violation(code_violation),
        .noise_event(noise_event), .noise_count_zero(noise_count_zero),
        .noise_threshold_load(noise_threshold_load), .state_count_zero(state_count_zero),
        .state_threshold_load(state_threshold_load), .connection_event_reg(conn_reg),
        .connection_event_mask(conn_mask), .elastic_overflow(elastic_overflow),
        .elastic_underflow(elastic_underflow), .cascade_enable(cascade_enable),
        .cascade_ready(cascade_ready), .cascade_go(cascade_go), .rx_enable_mask_a(mask_a),
        .rx_enable_mask_b(mask_b), .cbus_addr(cbus_addr), .cbus_rd(cbus_rd), .cbus_wr(cbus_wr),
        .cbus_wdata(cbus_wdata), .cbus_rdata(cbus_rdata), .group_a_summary(group_a_summary),
        .group_b_summary(group_b_summary));

    smt_host host (.clk(clk), .cbus_addr(cbus_addr), .cbus_rd(cbus_rd), .cbus_wr(cbus_wr),
        .cbus_wdata(cbus_wdata), .cbus_rdata(cbus_rdata));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // read a register and compare one bit
    task automatic bit_is(input logic [4:0] a, input int b, input logic v);
        logic [7:0] d;
        repeat (3) @(posedge clk);
        host.rd(a, d);
        chk({7'h00, d[b]}, {7'h00, v});
    endtask : bit_is

    // n symbol pairs, one strobe each with a gap between
    task automatic pairs(input logic [9:0] code, input int n);
        repeat (n) begin
            @(posedge clk);
            pair_valid <= 1'b1;
            pair_code <= code;
            @(posedge clk);
            pair_valid <= 1'b0;
        end
    endtask : pairs

    // one-cycle strobe on the chosen pulsed input
    task pulse(input int k);
        @(posedge clk);
        strobe[k] <= 1'b1;
        @(posedge clk);
        strobe[k] <= 1'b0;
    endtask : pulse

    task automatic t_reset;
        logic [7:0] d;
        host.rd(RA, d);
        chk(d, 8'h20);
        host.rd(RB, d);
        chk(d, 8'h02);
        chk({6'h00, group_a_summary, group_b_summary}, 8'h00);
        host.rd(5'h1F, d);
        chk(d, 8'h00);
    endtask : t_reset

    // both limit flags: hold until reload, count limit also needs a clear
    task automatic t_limits;
        pulse(NLOAD);
        pulse(SLOAD);
        host.clr(RA);
        host.clr(RB);
        bit_is(RA, 5, 1'b0);
        bit_is(RB, 1, 1'b0);
        pulse(NZERO);
        pulse(SZERO);
        host.clr(RA);
        host.clr(RB);
        bit_is(RA, 5, 1'b1);
        bit_is(RB, 1, 1'b1);
        pulse(NLOAD);
        pulse(SLOAD);
        bit_is(RB, 1, 1'b1);
        host.clr(RA);
        host.clr(RB);
        bit_is(RA, 5, 1'b0);
        bit_is(RB, 1, 1'b0);
    endtask : t_limits

    // eight-pair states: seven pairs fall short, the eighth enters
    task automatic t_runs;
        logic [9:0] codes [3] = '{`SYM_QUIET_PAIR, `SYM_HALT_PAIR, `SYM_MASTER_PAIR};
        for (int i = 0; i < 3; i++) begin
            host.clr(RA);
            pairs(codes[i], 7);
            bit_is(RA, i + 1, 1'b0);
            pairs(codes[i], 1);
            bit_is(RA, i + 1, 1'b1);
        end
    endtask : t_runs

    task automatic t_idle_active;
        host.clr(RB);
        pairs(`SYM_IDLE_PAIR, 1);
        bit_is(RB, 0, 1'b0);
        pairs(`SYM_IDLE_PAIR, 1);
        bit_is(RB, 0, 1'b1);
        pairs(`SYM_IDLE_PAIR, 5);
        bit_is(RB, 6, 1'b0);
        pairs(`SYM_IDLE_PAIR, 1);
        bit_is(RB, 6, 1'b1);
        pulse(VIOL);
        bit_is(RB, 3, 1'b1);
        bit_is(RB, 7, 1'b0);
        pairs(`SYM_JK_PAIR, 1);
        bit_is(RB, 2, 1'b1);
    endtask : t_idle_active

    task automatic t_noise;
        pulse(VIOL);
        host.clr(RA);
        repeat (15) pulse(NOISE);
        bit_is(RA, 4, 1'b0);
        pulse(NOISE);
        bit_is(RA, 4, 1'b1);
        bit_is(RA, 6, 1'b1);
        // a saturated noise count outranks a violation, so leave through no-signal first
        @(posedge clk) carrier_detect_in <= 1'b0;
        repeat (2) @(posedge clk);
        carrier_detect_in <= 1'b1;
        pulse(VIOL);
        bit_is(RA, 7, 1'b1);
    endtask : t_noise

    // connection hit, cascade window, elastic faults, group b summary
    task automatic t_events_b;
        host.clr(RB);
        conn_reg <= 8'h10;
        conn_mask <= 8'h01;
        bit_is(RB, 4, 1'b0);
        conn_mask <= 8'h10;
        bit_is(RB, 4, 1'b1);
        conn_reg <= 8'h00;
        host.clr(RB);
        cascade_enable <= 1'b1;
        cascade_ready <= 1'b1;
        @(posedge clk) cascade_ready <= 1'b0;
        repeat (2) @(posedge clk);
        cascade_go <= 1'b1;
        bit_is(RB, 4, 1'b0);
        cascade_go <= 1'b0;
        cascade_ready <= 1'b1;
        @(posedge clk) cascade_ready <= 1'b0;
        repeat (4) @(posedge clk); // let the start window run out before the read
        bit_is(RB, 4, 1'b1);
        cascade_enable <= 1'b0;
        host.clr(RB);
        pulse(OVER);
        bit_is(RB, 5, 1'b1);
        host.clr(RB);
        pulse(UNDER);
        bit_is(RB, 5, 1'b1);
        mask_b <= 8'hDF;
        repeat (3) @(posedge clk);
        chk({7'h00, group_b_summary}, 8'h00);
        mask_b <= 8'h20;
        repeat (3) @(posedge clk);
        chk({7'h00, group_b_summary}, 8'h01);
    endtask : t_events_b

    // a clear during a live set loses; the bit then stays after carrier returns
    task automatic t_carrier;
        carrier_detect_in <= 1'b0;
        host.clr(RA);
        bit_is(RA, 0, 1'b1);
        mask_a <= 8'h01;
        repeat (3) @(posedge clk);
        chk({7'h00, group_a_summary}, 8'h01);
        mask_a <= 8'h00;
        carrier_detect_in <= 1'b1;
        repeat (3) @(posedge clk);
        chk({7'h00, group_a_summary}, 8'h00);
        repeat (10) @(posedge clk);
        bit_is(RA, 0, 1'b1);
    endtask : t_carrier

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_reset();
        t_limits();
        t_runs();
        t_idle_active();
        t_noise();
        t_events_b();
        t_carrier();
        report_and_stop();
    end

    // watchdog, far beyond the few hundred cycles the tests take
    initial begin
        #400000;
        mismatches++;
        report_and_stop();
    end
endmodule : rx_line_state_event_regs_test
`default_nettype wire
